// ==== psr_host_ctrl.sv ====
// Host-side controller for an asynchronous 128K x 8 pseudo-static RAM.
// Assumes the RAM pins are wired directly; data pins are in/out/enable.
`timescale 1ns/1ns
module psr_host_ctrl #(
  parameter int PWRUP_CYC = psr_pkg::PWRUP_CYC
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        reqValid,
  input  wire logic                        reqWrite,
  input  wire logic [psr_pkg::ADDR_W-1:0]  reqAddr,
  input  wire logic [psr_pkg::DATA_W-1:0]  reqWdata,
  output logic                             reqReady,
  output logic                             rspValid,
  output logic      [psr_pkg::DATA_W-1:0]  rspRdata,
  input  wire logic                        selfRefReq,
  output logic                             selfRefActive,
  output logic                             initDone,
  output logic                             ceN,
  output logic                             cs,
  output logic                             oeN,
  output logic                             weN,
  output logic                             refresh_strobe_n,
  output logic      [psr_pkg::ADDR_W-1:0]  word_address,
  output logic      [psr_pkg::DATA_W-1:0]  data_pins_out,
  output logic                             data_pins_oe_n,
  input  wire logic [psr_pkg::DATA_W-1:0]  data_pins_in
);
  // ****************************************
  // Declarations
  // ****************************************
  typedef logic [psr_pkg::CNT_W-1:0] psr_cnt_t;

  function automatic psr_cnt_t cyc(input int n);
    cyc = psr_cnt_t'(n - 1);
  endfunction : cyc

  psr_pkg::psr_state_t          state_r, state_nxt;
  psr_cnt_t                     cnt_r, cnt_nxt;
  logic [psr_pkg::BURST_W-1:0]  burst_r, burst_nxt;
  logic                         init_r, init_nxt;
  logic                         ceN_r, ceN_nxt, cs_r, cs_nxt, oeN_r, oeN_nxt;
  logic                         weN_r, weN_nxt, rfN_r, rfN_nxt;
  logic [psr_pkg::ADDR_W-1:0]   addr_r, addr_nxt;
  logic [psr_pkg::DATA_W-1:0]   dout_r, dout_nxt, rdata_r, rdata_nxt;
  logic                         doe_r, doe_nxt, rsp_r, rsp_nxt;
  logic [psr_pkg::DATA_W-1:0]   dinMeta_r, dinSync_r;
  logic                         refreshDue, doneRefresh, inSelf;

  localparam logic [psr_pkg::BURST_W-1:0] BURST_ONE = 10'h001;

  // ****************************************
  // Pin input synchroniser
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dinMeta_r <= '0;
      dinSync_r <= '0;
    end
    else
    begin
      dinMeta_r <= data_pins_in;
      dinSync_r <= dinMeta_r;
    end
  end

  // ****************************************
  // Refresh scheduling
  // ****************************************
  assign inSelf      = (state_r == psr_pkg::ST_SELF) || (state_r == psr_pkg::ST_SELF_EXIT);
  assign doneRefresh = (state_r == psr_pkg::ST_REFRESH) && (cnt_r == '0);

  psr_refresh_timer u_timer (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .hold       (inSelf),
    .doneRefresh(doneRefresh),
    .refreshDue (refreshDue)
  );

  // Requests wait behind any pending refresh or burst
  assign reqReady = (state_r == psr_pkg::ST_IDLE) && init_r && !refreshDue &&
                    (burst_r == '0) && !selfRefReq;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    burst_nxt = burst_r;
    init_nxt  = init_r;
    ceN_nxt   = ceN_r;
    cs_nxt    = cs_r;
    oeN_nxt   = oeN_r;
    weN_nxt   = weN_r;
    rfN_nxt   = rfN_r;
    addr_nxt  = addr_r;
    dout_nxt  = dout_r;
    doe_nxt   = doe_r;
    rdata_nxt = rdata_r;
    rsp_nxt   = 1'b0;
    unique case (state_r)
      psr_pkg::ST_PWRUP:
      begin
        if (cnt_r == '0)
        begin
          burst_nxt = BURST_ONE * psr_pkg::BURST_W'(psr_pkg::INIT_DUMMY);
          state_nxt = psr_pkg::ST_IDLE;
        end
      end
      psr_pkg::ST_IDLE:
      begin
        if (burst_r != '0 || refreshDue)
        begin
          rfN_nxt   = 1'b0;
          cnt_nxt   = cyc(psr_pkg::RCYC_CYC);
          state_nxt = psr_pkg::ST_REFRESH;
        end
        else if (selfRefReq && init_r)
        begin
          rfN_nxt   = 1'b0;
          cnt_nxt   = cyc(psr_pkg::SELF_CYC);
          state_nxt = psr_pkg::ST_SELF;
        end
        else if (reqValid && reqReady)
        begin
          ceN_nxt  = 1'b0;
          cs_nxt   = 1'b1;
          addr_nxt = reqAddr;
          if (reqWrite)
          begin
            // Write strobe falls with enable, outputs stay off
            weN_nxt   = 1'b0;
            oeN_nxt   = 1'b1;
            dout_nxt  = reqWdata;
            doe_nxt   = 1'b0;
            cnt_nxt   = cyc(psr_pkg::CE_CYC);
            state_nxt = psr_pkg::ST_WRITE;
          end
          else
          begin
            oeN_nxt   = 1'b0;
            cnt_nxt   = cyc(psr_pkg::READ_CYC);
            state_nxt = psr_pkg::ST_READ;
          end
        end
      end
      psr_pkg::ST_READ:
      begin
        if (cnt_r == '0)
        begin
          rdata_nxt = dinSync_r;
          rsp_nxt   = 1'b1;
          ceN_nxt   = 1'b1;
          oeN_nxt   = 1'b1;
          cs_nxt    = 1'b0;
          cnt_nxt   = cyc(psr_pkg::PRECHG_CYC);
          state_nxt = psr_pkg::ST_PRECHG;
        end
      end
      psr_pkg::ST_WRITE:
      begin
        if (cnt_r == '0)
        begin
          // Both strobes rise together; data held one more cycle
          ceN_nxt   = 1'b1;
          weN_nxt   = 1'b1;
          cs_nxt    = 1'b0;
          rsp_nxt   = 1'b1;
          cnt_nxt   = cyc(psr_pkg::PRECHG_CYC);
          state_nxt = psr_pkg::ST_PRECHG;
        end
      end
      psr_pkg::ST_PRECHG:
      begin
        doe_nxt = 1'b1;
        if (cnt_r == '0)
          state_nxt = psr_pkg::ST_IDLE;
      end
      psr_pkg::ST_REFRESH:
      begin
        if (cnt_r == psr_cnt_t'(psr_pkg::RCYC_CYC - psr_pkg::RLOW_CYC))
          rfN_nxt = 1'b1;
        if (cnt_r == '0)
        begin
          if (burst_r != '0)
          begin
            burst_nxt = burst_r - BURST_ONE;
            if (burst_r == BURST_ONE)
              init_nxt = 1'b1;
          end
          state_nxt = psr_pkg::ST_IDLE;
        end
      end
      psr_pkg::ST_SELF:
      begin
        // Strobe stays low past the minimum, so it cannot read as auto refresh
        if (cnt_r == '0 && !selfRefReq)
        begin
          rfN_nxt   = 1'b1;
          cnt_nxt   = cyc(psr_pkg::SEXIT_CYC);
          state_nxt = psr_pkg::ST_SELF_EXIT;
        end
      end
      psr_pkg::ST_SELF_EXIT:
      begin
        if (cnt_r == '0)
        begin
          burst_nxt = psr_pkg::BURST_W'(psr_pkg::REF_CYCLES);
          state_nxt = psr_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= psr_pkg::ST_PWRUP;
      cnt_r   <= cyc(PWRUP_CYC);
      burst_r <= '0;
      init_r  <= 1'b0;
      ceN_r   <= 1'b1;
      cs_r    <= 1'b0;
      oeN_r   <= 1'b1;
      weN_r   <= 1'b1;
      rfN_r   <= 1'b1;
      addr_r  <= '0;
      dout_r  <= '0;
      doe_r   <= 1'b1;
      rdata_r <= '0;
      rsp_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      burst_r <= burst_nxt;
      init_r  <= init_nxt;
      ceN_r   <= ceN_nxt;
      cs_r    <= cs_nxt;
      oeN_r   <= oeN_nxt;
      weN_r   <= weN_nxt;
      rfN_r   <= rfN_nxt;
      addr_r  <= addr_nxt;
      dout_r  <= dout_nxt;
      doe_r   <= doe_nxt;
      rdata_r <= rdata_nxt;
      rsp_r   <= rsp_nxt;
    end
  end

  assign ceN              = ceN_r;
  assign cs               = cs_r;
  assign oeN              = oeN_r;
  assign weN              = weN_r;
  assign refresh_strobe_n = rfN_r;
  assign word_address     = addr_r;
  assign data_pins_out    = dout_r;
  assign data_pins_oe_n   = doe_r;
  assign rspRdata         = rdata_r;
  assign rspValid         = rsp_r;
  assign initDone         = init_r;
  assign selfRefActive    = inSelf;

  // ****************************************
  // Checks
  // ****************************************
  logic [psr_pkg::CNT_W-1:0] ceLow_r, rfLow_r, gap_r;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ceLow_r <= '0;
      rfLow_r <= '0;
      gap_r   <= '0;
    end
    else
    begin
      ceLow_r <= ceN_r ? '0 : ceLow_r + 1'b1;
      rfLow_r <= rfN_r ? '0 : rfLow_r + 1'b1;
      // The power-up wait owes no refresh, so it does not count as a gap
      gap_r   <= (!rfN_r || inSelf || burst_r != '0 || state_r == psr_pkg::ST_PWRUP) ?
                 '0 : gap_r + 1'b1;
    end
  end

  a_read_no_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!ceN_r && cs_r && !oeN_r && weN_r) |-> doe_r) else $error("drove pins during read");
  a_write_strobe_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(ceN_r) && cs_r |-> (!weN_r && !doe_r && oeN_r) || (weN_r && !oeN_r))
    else $error("access started with bad strobes");
  a_write_data_held: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(weN_r) |-> $rose(ceN_r) && !doe_r && $stable(dout_r)) else $error("write data lost");
  a_ce_max_width: assert property (@(posedge core_clk) disable iff (!rst_n)
    ceLow_r < psr_cnt_t'(psr_pkg::CE_MAX_CYC)) else $error("enable low too long");
  a_refresh_ce_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    !rfN_r |-> ceN_r && doe_r) else $error("refresh with enable low");
  a_auto_pulse_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(rfN_r) && state_r == psr_pkg::ST_REFRESH
    |-> !rfN_r[*3] ##1 rfN_r) else $error("auto refresh pulse wrong");
  a_self_min_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rfN_r) |-> ($past(rfLow_r) < psr_cnt_t'(psr_pkg::RLOW_CYC + 1)) ||
    ($past(rfLow_r) >= psr_cnt_t'(psr_pkg::SELF_CYC - 1))) else $error("ambiguous strobe");
  a_self_exit_burst: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(inSelf) |-> ##[1:3] !rfN_r) else $error("no burst after self refresh");
  a_refresh_interval: assert property (@(posedge core_clk) disable iff (!rst_n)
    gap_r < psr_cnt_t'(psr_pkg::REF_INT_CYC * 2)) else $error("refresh overdue");
  a_hold_during_refresh_strobe_n: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_r == psr_pkg::ST_REFRESH || refreshDue) |-> !reqReady) else $error("ready in refresh");
  a_init_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    !init_r |-> ceN_r && !reqReady) else $error("access before init");

  c_read_done: cover property (@(posedge core_clk) disable iff (!rst_n)
    rsp_r && oeN_r && doe_r && state_r == psr_pkg::ST_PRECHG);
  c_write_done: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(weN_r));
  c_self_exit: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(inSelf));
endmodule : psr_host_ctrl

// ==== psr_pkg.sv ====
// Constants and types shared by the pseudo-static RAM host controller.
// Assumes a 100 MHz core clock; every pin timing is derived from it here.
package psr_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W        = 17;
  localparam int DATA_W        = 8;
  localparam int WORDS         = 131072;
  localparam int CLK_PERIOD_NS = 10;

  // ****************************************
  // Pin timing, slower grade used so either grade works
  // ****************************************
  localparam int T_CE_MIN_NS      = 80;
  localparam int T_CE_MAX_NS      = 10000;
  localparam int T_PRECHG_NS      = 40;
  localparam int T_REFRESH_STROBE_N_PULSE_NS  = 30;
  localparam int T_REFRESH_STROBE_N_CYCLE_NS  = 130;
  localparam int T_SELF_MIN_NS    = 8000;
  localparam int T_SELF_EXIT_NS   = 160;
  localparam int T_PWRUP_NS       = 100000;
  localparam int T_REF_PERIOD_NS  = 8000000;
  localparam int REF_CYCLES       = 512;
  localparam int INIT_DUMMY       = 9;
  localparam int SYNC_LAT         = 2;

  // Least times round up, longest times round down
  localparam int CE_CYC     = (T_CE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_MAX_CYC = T_CE_MAX_NS / CLK_PERIOD_NS;
  localparam int PRECHG_CYC = (T_PRECHG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RLOW_CYC   = (T_REFRESH_STROBE_N_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCYC_CYC   = (T_REFRESH_STROBE_N_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELF_CYC   = (T_SELF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEXIT_CYC  = (T_SELF_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRUP_CYC  = (T_PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_INT_CYC = T_REF_PERIOD_NS / (REF_CYCLES * CLK_PERIOD_NS);
  localparam int READ_CYC   = CE_CYC + SYNC_LAT;

  localparam int CNT_W   = 14;
  localparam int BURST_W = 10;
  localparam int OWED_W  = 4;

  typedef enum logic [3:0] {
    ST_PWRUP,
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_PRECHG,
    ST_REFRESH,
    ST_SELF,
    ST_SELF_EXIT
  } psr_state_t;
endpackage : psr_pkg

// ==== psr_refresh_timer.sv ====
// Periodic refresh scheduler: counts the refresh interval and keeps a
// saturating tally of refresh cycles owed to the memory.
// Assumes the caller pulses doneRefresh once per finished refresh cycle.
`timescale 1ns/1ns
module psr_refresh_timer (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic hold,
  input  wire logic doneRefresh,
  output logic      refreshDue
);
  logic [psr_pkg::CNT_W-1:0]  tick_r;
  logic [psr_pkg::CNT_W-1:0]  tick_nxt;
  logic [psr_pkg::OWED_W-1:0] owed_r;
  logic [psr_pkg::OWED_W-1:0] owed_nxt;
  logic                       tickEnd;

  localparam logic [psr_pkg::CNT_W-1:0] TICK_LAST =
    psr_pkg::CNT_W'(psr_pkg::REF_INT_CYC - 1);
  localparam logic [psr_pkg::OWED_W-1:0] OWED_ONE = 4'h1;

  assign tickEnd    = (tick_r == TICK_LAST);
  assign refreshDue = (owed_r != '0);

  always_comb
  begin
    tick_nxt = tickEnd ? '0 : tick_r + 1'b1;
    owed_nxt = owed_r;
    if (hold)
    begin
      // Self refresh keeps the cells itself, so nothing is owed then
      tick_nxt = '0;
      owed_nxt = '0;
    end
    else if (tickEnd && !doneRefresh)
    begin
      if (owed_r != '1)
        owed_nxt = owed_r + OWED_ONE;
    end
    else if (!tickEnd && doneRefresh && owed_r != '0)
    begin
      owed_nxt = owed_r - OWED_ONE;
    end
    // A tick arriving with a completion leaves the tally unchanged: the two cancel
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_r <= '0;
      owed_r <= '0;
    end
    else
    begin
      tick_r <= tick_nxt;
      owed_r <= owed_nxt;
    end
  end

  a_owed_no_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
    (owed_r == '1 && !hold) |=> (owed_r != '0)) else $error("owed tally wrapped");
endmodule : psr_refresh_timer

// ==== psr_ram_model.sv ====
// Behavioural pseudo-static RAM as seen at its pins, clockless.
// Assumes the bench resolves the shared data wire and feeds it back as busIn.
`timescale 1ns/1ns
module psr_ram_model (
  input  wire logic                       ceN,
  input  wire logic                       cs,
  input  wire logic                       oeN,
  input  wire logic                       weN,
  input  wire logic                       refresh_strobe_n,
  input  wire logic [psr_pkg::ADDR_W-1:0] word_address,
  input  wire logic [psr_pkg::DATA_W-1:0] busIn,
  input  wire logic                       slowAccess,
  output logic      [psr_pkg::DATA_W-1:0] memOut,
  output logic                            memDrive,
  output int                              autoCnt,
  output int                              selfCnt,
  output int                              longCe
);
  logic [psr_pkg::DATA_W-1:0] mem [psr_pkg::WORDS];
  logic [psr_pkg::ADDR_W-1:0] wrAddr;
  logic [psr_pkg::DATA_W-1:0] wrData;
  logic                       wrArm = 1'b0;
  logic                       rdOk  = 1'b0;
  logic                       rfArm = 1'b0;
  time                        ceT   = 0;
  time                        rfT   = 0;

  initial
  begin
    autoCnt = 0;
    selfCnt = 0;
    longCe  = 0;
  end

  // Drivers on only for a true read; write strobe low keeps them off
  assign memDrive = !ceN && cs && !oeN && weN;
  // Before access time the pins show the inverted low address byte, not the stored one
  assign memOut = rdOk ? mem[word_address] : ~word_address[7:0];

  always @(negedge ceN)
  begin
    ceT  = $time;
    rdOk = 1'b0;
    #(slowAccess ? 70 : 20);
    rdOk = !ceN;
  end

  always @(posedge ceN)
  begin
    rdOk = 1'b0;
    if ($time - ceT > 10000)
      longCe++;
  end

  always @*
    if (!ceN && cs && !weN)
    begin
      wrArm  = 1'b1;
      wrAddr = word_address;
      wrData = busIn;
    end

  // Whichever strobe rises first commits the byte
  always @(posedge ceN or posedge weN)
    if (wrArm)
    begin
      mem[wrAddr] = wrData;
      wrArm       = 1'b0;
    end

  always @(negedge refresh_strobe_n)
  begin
    rfT   = $time;
    rfArm = ceN;
  end

  // Row addressing is internal in both refresh kinds, no address is read
  always @(posedge refresh_strobe_n)
    if (rfArm)
    begin
      rfArm = 1'b0;
      if ($time - rfT >= 8000)
        selfCnt++;
      else
        autoCnt++;
    end
endmodule : psr_ram_model

// ==== test_psr_host_ctrl.sv ====
// Self-checking bench for the pseudo-static RAM host controller.
// Assumes the design package and the RAM model are compiled first.
`timescale 1ns/1ns
module test_psr_host_ctrl;
  localparam int PWRUP = 20;
  logic                       core_clk = 1'b0;
  logic                       rst_n    = 1'b0;
  logic                       reqValid = 1'b0;
  logic                       reqWrite = 1'b0;
  logic [psr_pkg::ADDR_W-1:0] reqAddr  = '0;
  logic [psr_pkg::DATA_W-1:0] reqWdata = '0;
  logic                       selfRefReq = 1'b0;
  logic                       slowAccess = 1'b0;
  logic                       reqReady, rspValid, selfRefActive, initDone, memDrive;
  logic                       ceN, cs, oeN, weN, refresh_strobe_n, data_pins_oe_n;
  logic [psr_pkg::ADDR_W-1:0] word_address;
  logic [psr_pkg::DATA_W-1:0] rspRdata, data_pins_out, memOut, busVal;
  logic [psr_pkg::DATA_W-1:0] floatPat = 8'h5a;
  logic [15:0]                lfsr     = 16'h0037;
  logic [psr_pkg::DATA_W-1:0] shadow [int];
  logic [psr_pkg::ADDR_W-1:0] used [$];
  int                         autoCnt, selfCnt, longCe;
  int                         errorCnt = 0;
  int                         nTests   = 0;
  int                         cyc      = 0;

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  // An undriven wire churns every cycle so a stale byte never reads as good
  assign busVal = !data_pins_oe_n ? data_pins_out : (memDrive ? memOut : floatPat);
  always @(posedge core_clk)
    floatPat <= floatPat + 8'h3b;

  psr_host_ctrl #(.PWRUP_CYC(PWRUP)) psr_host_ctrl_i (
    .core_clk(core_clk), .rst_n(rst_n), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid),
    .rspRdata(rspRdata), .selfRefReq(selfRefReq), .selfRefActive(selfRefActive),
    .initDone(initDone), .ceN(ceN), .cs(cs), .oeN(oeN), .weN(weN),
    .refresh_strobe_n(refresh_strobe_n), .word_address(word_address),
    .data_pins_out(data_pins_out), .data_pins_oe_n(data_pins_oe_n), .data_pins_in(busVal));

  psr_ram_model psr_ram_model_i (
    .ceN(ceN), .cs(cs), .oeN(oeN), .weN(weN), .refresh_strobe_n(refresh_strobe_n),
    .word_address(word_address), .busIn(busVal), .slowAccess(slowAccess),
    .memOut(memOut), .memDrive(memDrive), .autoCnt(autoCnt), .selfCnt(selfCnt),
    .longCe(longCe));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic int answer_lat(input logic wr);
    return wr ? psr_pkg::CE_CYC : psr_pkg::READ_CYC;
  endfunction : answer_lat

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // Entered and left at a falling edge; request held until taken
  task automatic access(input logic wr, input logic [16:0] a, input logic [7:0] d);
    int n;
    n        = 0;
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr  = a;
    reqWdata = d;
    while (reqReady !== 1'b1 && n < 9000)
    begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    reqValid = 1'b0;
    n        = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
      if (n == 1)
      begin
        check({ceN, cs, oeN, weN}, wr ? 4'h6 : 4'h5);
        check(word_address, a);
        check(data_pins_oe_n, !wr);
        if (wr)
          check(data_pins_out, d);
      end
    end
    while (rspValid !== 1'b1 && n < 40);
    check(n, answer_lat(wr));
    if (wr)
    begin
      shadow[a] = d;
      used.push_back(a);
    end
    else
      check(rspRdata, shadow[a]);
    @(negedge core_clk);
  endtask : access

  // ****************************************
  // Monitor and hang guard
  // ****************************************
  // Ceiling is about two and a half times the cycles the sequence below needs
  always @(posedge core_clk)
  begin
    // Look just after the edge so values launched by it have settled
    #1;
    cyc++;
    if (rst_n)
    begin
      check(!data_pins_oe_n && memDrive, 1'b0);
      check(!refresh_strobe_n && !ceN, 1'b0);
      check(!refresh_strobe_n && reqReady, 1'b0);
    end
    if (cyc > 40000)
    begin
      errorCnt++;
      $display("[ERR] %0t run did not finish", $time);
      summarize();
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    int a0;
    int t0;
    logic [16:0] a;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    t0    = cyc;
    while (initDone !== 1'b1 && cyc - t0 < 400)
      @(negedge core_clk);
    check(autoCnt, 9);
    check(cyc - t0 >= PWRUP + 9 * 13, 1'b1);
    a0 = autoCnt;
    repeat (4 * psr_pkg::REF_INT_CYC) @(negedge core_clk);
    check((autoCnt - a0) inside {[3:5]}, 1'b1);
    access(1'b1, 17'h00000, 8'ha5);
    access(1'b1, 17'h1ffff, 8'h5a);
    access(1'b0, 17'h00000, 8'h00);
    access(1'b0, 17'h1ffff, 8'h00);
    repeat (40)
    begin
      lfsr       = lfsr_next(lfsr);
      slowAccess = lfsr[0];
      a          = {lfsr, lfsr[3]};
      if (lfsr[1])
        access(1'b1, a, lfsr[11:4]);
      else
        access(1'b0, used[lfsr % used.size()], 8'h00);
    end
    selfRefReq = 1'b1;
    repeat (1000) @(negedge core_clk);
    check(selfRefActive, 1'b1);
    check(refresh_strobe_n, 1'b0);
    selfRefReq = 1'b0;
    a0         = autoCnt;
    access(1'b0, 17'h1ffff, 8'h00);
    check((autoCnt - a0) inside {[512:517]}, 1'b1);
    check(selfCnt, 1);
    check(longCe, 0);
    summarize();
  end
endmodule : test_psr_host_ctrl
